/* File: logic/rpmls_top.sv */
// Receive/PHY control register with PHY mode resolution and LED routing, AXI4-Lite slave.
// Assumes synchronous inputs on i_clk_sys, synchronous active-high reset, one access at a time.
//
// Function
// R01 - Manual mode: speed select bit sets speed, 1 is 100M, 0 is 10M
// R02 - With MAC autoneg select set, speed select bit is ignored; negotiated speed used when PHY autoneg is also set
// R03 - MAC autoneg set, PHY autoneg clear: speed from PHY control speed bit
// R04 - Manual mode: duplex select bit sets duplex, 1 full, 0 half
// R05 - With MAC autoneg select set, duplex select is ignored; negotiated duplex used when PHY autoneg is also set
// R06 - MAC autoneg set, PHY autoneg clear: duplex from PHY control duplex bit
// R07 - PHY autonegotiates only when both autoneg bits are set, otherwise manual
// R08 - Software sets both autoneg enables, advertisement, and MAC full-duplex bit
// R09 - First LED from 3-bit selector: 0 any link, 1 reserved, 2..7 indications
// R10 - Second LED has its own selector with the same encoding
// R11 - Default LED selection shows OR of 100M and 10M link
// R12 - Software writes zero to reserved bits
// R13 - 16-bit register: speed 13, duplex 12, autoneg 11, LEDs 7:5 and 4:2, reset zero
// R14 - Full-duplex bit in transmit control; clear keeps receive abort on collision active
`timescale 1ns/1ps
`default_nettype none

module rpmls_top (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [31:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // PHY status and negotiation outcome
  input wire rpmls_pkg::rpmls_ind_type i_ind,
  input wire logic i_mac_autoneg_select_speed_100,
  input wire logic i_mac_autoneg_select_full_duplex,
  // PHY mode, MAC duplex and LED pins
  output rpmls_pkg::rpmls_mode_type o_phy_mode,
  output logic o_mac_full_duplex_ctl,
  output logic o_rx_abort_coll_en,
  output logic o_first_led_pin,
  output logic o_second_led_pin
);

  logic [15:0] rx_phy_control_r;
  logic [15:0] tx_control_r;
  logic [15:0] phy_control_r;
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  rpmls_pkg::rpmls_mode_type mode_r;
  logic led_a_r;
  logic led_b_r;
  logic fdx_r;
  logic abort_en_r;

  // LED routing; code 1 is reserved and drives the LED off
  function automatic logic led_pick(input logic [2:0] sel, input rpmls_pkg::rpmls_ind_type ind);
    logic res;
    res = 1'b0;
    case (sel)
      rpmls_pkg::RPMLS_LED_ANY_LINK: res = ind.link_100m_ind | ind.link_10m_ind; // R11
      rpmls_pkg::RPMLS_LED_RSVD: res = 1'b0;
      rpmls_pkg::RPMLS_LED_LINK10: res = ind.link_10m_ind;
      rpmls_pkg::RPMLS_LED_FDX: res = ind.full_duplex_ind;
      rpmls_pkg::RPMLS_LED_TXRX: res = ind.txrx_activity_ind;
      rpmls_pkg::RPMLS_LED_LINK100: res = ind.link_100m_ind;
      rpmls_pkg::RPMLS_LED_RX: res = ind.rx_activity_ind;
      rpmls_pkg::RPMLS_LED_TX: res = ind.tx_activity_ind;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // Byte-lane merge, keeping only writable bits so reserved bits stay zero
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st, input logic [15:0] wmask);
    logic [15:0] nv;
    nv = old;
    if (st[0]) begin
      nv[7:0] = wd[7:0];
    end
    if (st[1]) begin
      nv[15:8] = wd[15:8];
    end
    return nv & wmask;
  endfunction

  // Field decode
  wire logic mac_speed_select = rx_phy_control_r[rpmls_pkg::RPMLS_POS_SPEED];
  wire logic duplex_select = rx_phy_control_r[rpmls_pkg::RPMLS_POS_DUPLEX];
  wire logic mac_autoneg_select = rx_phy_control_r[rpmls_pkg::RPMLS_POS_MAC_MAC_AUTONEG_SELECT];
  wire logic [2:0] led_a_sel = rx_phy_control_r[rpmls_pkg::RPMLS_POS_LED_A +: 3];
  wire logic [2:0] led_b_sel = rx_phy_control_r[rpmls_pkg::RPMLS_POS_LED_B +: 3];
  wire logic phy_autoneg_enable = phy_control_r[rpmls_pkg::RPMLS_POS_PHY_PHY_AUTONEG_ENABLE];
  wire logic phy_speed_bit = phy_control_r[rpmls_pkg::RPMLS_POS_PHY_SPEED];
  wire logic phy_duplex_bit = phy_control_r[rpmls_pkg::RPMLS_POS_PHY_DUPLEX];
  wire logic mac_full_duplex_ctl = tx_control_r[rpmls_pkg::RPMLS_POS_MAC_FDX];

  // Mode resolution
  wire logic mac_autoneg_select_mode = mac_autoneg_select & phy_autoneg_enable; // R07
  wire logic speed_nxt = !mac_autoneg_select ? mac_speed_select : // R01
                         mac_autoneg_select_mode ? i_mac_autoneg_select_speed_100 : // R02
                         phy_speed_bit; // R03
  wire logic duplex_nxt = !mac_autoneg_select ? duplex_select : // R04
                          mac_autoneg_select_mode ? i_mac_autoneg_select_full_duplex : // R05
                          phy_duplex_bit; // R06
  wire rpmls_pkg::rpmls_mode_type mode_nxt = '{autoneg_mode: mac_autoneg_select_mode, speed_100: speed_nxt,
                                               full_duplex: duplex_nxt};
  wire logic led_a_nxt = led_pick(led_a_sel, i_ind); // R09
  wire logic led_b_nxt = led_pick(led_b_sel, i_ind); // R10

  // Bus decode
  wire logic wr_go = aw_held_r & w_held_r & !o_bvalid;
  wire logic [9:0] wr_addr = awaddr_r[9:0];
  wire logic wr_rpc = wr_go && (wr_addr == rpmls_pkg::RPMLS_ADDR_RX_PHY_CONTROL);
  wire logic wr_txc = wr_go && (wr_addr == rpmls_pkg::RPMLS_ADDR_TX_CONTROL);
  wire logic wr_phc = wr_go && (wr_addr == rpmls_pkg::RPMLS_ADDR_PHY_CONTROL);
  wire logic wr_ro = wr_go && (wr_addr == rpmls_pkg::RPMLS_ADDR_PHY_STATUS);
  wire logic wr_hit = wr_rpc | wr_txc | wr_phc | wr_ro;
  wire logic wr_upper = (awaddr_r[31:10] != 22'h00_0000);
  wire logic rd_go = i_arvalid & o_arready;
  wire logic rd_upper = (i_araddr[31:10] != 22'h00_0000);
  wire logic [9:0] rd_addr = i_araddr[9:0];
  wire logic [15:0] status_word = {12'h000, mac_autoneg_select_mode, mode_r.speed_100, mode_r.full_duplex,
                                   abort_en_r};

  // Handshake next states; the readies are flops fed from these so no port is combinational
  wire logic aw_take = i_awvalid & o_awready;
  wire logic w_take = i_wvalid & o_wready;
  wire logic aw_held_nxt = !wr_go & (aw_held_r | aw_take);
  wire logic w_held_nxt = !wr_go & (w_held_r | w_take);
  wire logic bvalid_nxt = wr_go | (o_bvalid & !i_bready);
  wire logic rvalid_nxt = rd_go | (o_rvalid & !i_rready);
  logic [15:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 16'h0000;
    rd_ok = !rd_upper;
    case (rd_addr)
      rpmls_pkg::RPMLS_ADDR_RX_PHY_CONTROL: rd_word = rx_phy_control_r;
      rpmls_pkg::RPMLS_ADDR_TX_CONTROL: rd_word = tx_control_r;
      rpmls_pkg::RPMLS_ADDR_PHY_CONTROL: rd_word = phy_control_r;
      rpmls_pkg::RPMLS_ADDR_PHY_STATUS: rd_word = status_word;
      default: rd_ok = 1'b0;
    endcase
  end

  // Write channel state
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      o_bvalid <= 1'b0;
    end else if (i_ce) begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      o_bvalid <= bvalid_nxt;
    end
  end

  // Write payloads and response code
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      o_bresp <= rpmls_pkg::RPMLS_RESP_OKAY;
    end else if (i_ce) begin
      if (aw_take) begin
        awaddr_r <= i_awaddr;
      end
      if (w_take) begin
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      if (wr_go) begin
        o_bresp <= (wr_hit && !wr_upper) ? rpmls_pkg::RPMLS_RESP_OKAY :
                   rpmls_pkg::RPMLS_RESP_SLVERR;
      end
    end
  end

  // Ready flops; high after reset, low while a channel is held or an answer waits
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_arready <= 1'b1;
    end else if (i_ce) begin
      o_awready <= !aw_held_nxt & !bvalid_nxt;
      o_wready <= !w_held_nxt & !bvalid_nxt;
      o_arready <= !rvalid_nxt;
    end
  end

  // Register file; reserved bits masked off on write
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_phy_control_r <= rpmls_pkg::RPMLS_RPC_RESET; // R13
      tx_control_r <= rpmls_pkg::RPMLS_TXC_RESET;
      phy_control_r <= rpmls_pkg::RPMLS_PHC_RESET;
    end else if (i_ce && !wr_upper) begin
      if (wr_rpc) begin
        rx_phy_control_r <= merge16(rx_phy_control_r, wdata_r, wstrb_r,
                                    rpmls_pkg::RPMLS_RPC_WMASK); // R13
      end
      if (wr_txc) begin
        tx_control_r <= merge16(tx_control_r, wdata_r, wstrb_r, rpmls_pkg::RPMLS_TXC_WMASK);
      end
      if (wr_phc) begin
        phy_control_r <= merge16(phy_control_r, wdata_r, wstrb_r, rpmls_pkg::RPMLS_PHC_WMASK);
      end
    end
  end

  // Read channel; one cycle to rvalid
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= rpmls_pkg::RPMLS_RESP_OKAY;
    end else if (i_ce) begin
      if (rd_go) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_ok ? {16'h0000, rd_word} : 32'h0000_0000;
        o_rresp <= rd_ok ? rpmls_pkg::RPMLS_RESP_OKAY : rpmls_pkg::RPMLS_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Registered pin outputs; one cycle behind their causes
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mode_r <= '0;
      led_a_r <= 1'b0;
      led_b_r <= 1'b0;
      fdx_r <= 1'b0;
      abort_en_r <= 1'b1;
    end else if (i_ce) begin
      mode_r <= mode_nxt;
      led_a_r <= led_a_nxt;
      led_b_r <= led_b_nxt;
      fdx_r <= mac_full_duplex_ctl; // R08
      abort_en_r <= !mac_full_duplex_ctl; // R14
    end
  end

  assign o_phy_mode = mode_r;
  assign o_first_led_pin = led_a_r;
  assign o_second_led_pin = led_b_r;
  assign o_mac_full_duplex_ctl = fdx_r;
  assign o_rx_abort_coll_en = abort_en_r;

endmodule

`default_nettype wire

/* File: logic/rpmls_pkg.sv */
// Package for the receive/PHY control register block: offsets, fields, reset values, carriers.
// Assumes a 32-bit AXI4-Lite master and a single 40 MHz clock.
`default_nettype none

package rpmls_pkg;

  // Register byte addresses (printed offsets not all multiples of four: index times four)
  localparam logic [7:0] RPMLS_IDX_RX_PHY_CONTROL = 8'h0a;
  localparam logic [7:0] RPMLS_IDX_TX_CONTROL = 8'h0b;
  localparam logic [7:0] RPMLS_IDX_PHY_CONTROL = 8'h0c;
  localparam logic [7:0] RPMLS_IDX_PHY_STATUS = 8'h0d;
  localparam logic [9:0] RPMLS_ADDR_RX_PHY_CONTROL = {RPMLS_IDX_RX_PHY_CONTROL, 2'b00};
  localparam logic [9:0] RPMLS_ADDR_TX_CONTROL = {RPMLS_IDX_TX_CONTROL, 2'b00};
  localparam logic [9:0] RPMLS_ADDR_PHY_CONTROL = {RPMLS_IDX_PHY_CONTROL, 2'b00};
  localparam logic [9:0] RPMLS_ADDR_PHY_STATUS = {RPMLS_IDX_PHY_STATUS, 2'b00};

  // Receive/PHY control register fields
  localparam int RPMLS_POS_SPEED = 13;
  localparam int RPMLS_POS_DUPLEX = 12;
  localparam int RPMLS_POS_MAC_MAC_AUTONEG_SELECT = 11;
  localparam int RPMLS_POS_LED_A = 5;
  localparam int RPMLS_POS_LED_B = 2;
  localparam logic [15:0] RPMLS_RPC_WMASK = 16'h38fc;
  localparam logic [15:0] RPMLS_RPC_RESET = 16'h0000;

  // Transmit control (full-duplex bit) and PHY control mirror fields
  localparam int RPMLS_POS_MAC_FDX = 0;
  localparam int RPMLS_POS_PHY_SPEED = 13;
  localparam int RPMLS_POS_PHY_PHY_AUTONEG_ENABLE = 12;
  localparam int RPMLS_POS_PHY_DUPLEX = 8;
  localparam logic [15:0] RPMLS_TXC_WMASK = 16'h0001;
  localparam logic [15:0] RPMLS_PHC_WMASK = 16'h3100;
  localparam logic [15:0] RPMLS_TXC_RESET = 16'h0000;
  localparam logic [15:0] RPMLS_PHC_RESET = 16'h0000;

  // LED selector codes
  localparam logic [2:0] RPMLS_LED_ANY_LINK = 3'h0;
  localparam logic [2:0] RPMLS_LED_RSVD = 3'h1;
  localparam logic [2:0] RPMLS_LED_LINK10 = 3'h2;
  localparam logic [2:0] RPMLS_LED_FDX = 3'h3;
  localparam logic [2:0] RPMLS_LED_TXRX = 3'h4;
  localparam logic [2:0] RPMLS_LED_LINK100 = 3'h5;
  localparam logic [2:0] RPMLS_LED_RX = 3'h6;
  localparam logic [2:0] RPMLS_LED_TX = 3'h7;

  localparam logic [1:0] RPMLS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RPMLS_RESP_SLVERR = 2'h2;

  // Status indications from the PHY
  typedef struct packed {
    logic link_10m_ind;
    logic full_duplex_ind;
    logic txrx_activity_ind;
    logic link_100m_ind;
    logic rx_activity_ind;
    logic tx_activity_ind;
  } rpmls_ind_type;

  // Resolved PHY mode and outcome of negotiation
  typedef struct packed {
    logic autoneg_mode;
    logic speed_100;
    logic full_duplex;
  } rpmls_mode_type;

endpackage

`default_nettype wire

/* File: bench/rpmls_properties.sv */
// Port checks for the receive/PHY control block.
// Assumes a bind from the bench top and i_ce held high.
`timescale 1ns/1ps
`default_nettype none
module rpmls_properties (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Bus
  input wire logic i_bready,
  input wire logic o_bvalid,
  input wire logic i_rready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  // PHY side
  input wire rpmls_pkg::rpmls_ind_type i_ind,
  input wire logic i_mac_autoneg_select_speed_100,
  input wire logic i_mac_autoneg_select_full_duplex,
  input wire rpmls_pkg::rpmls_mode_type o_phy_mode,
  input wire logic o_mac_full_duplex_ctl,
  input wire logic o_rx_abort_coll_en,
  input wire logic o_first_led_pin,
  input wire logic o_second_led_pin
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  wire logic any_link = i_ind.link_100m_ind | i_ind.link_10m_ind;
  abort_inv_a: assert property (o_rx_abort_coll_en != o_mac_full_duplex_ctl)
    else $error("abort enable wrong");
  mac_autoneg_select_speed_a: assert property (o_phy_mode.autoneg_mode |->
    o_phy_mode.speed_100 == $past(i_mac_autoneg_select_speed_100)) else $error("speed wrong");
  mac_autoneg_select_duplex_select_a: assert property (o_phy_mode.autoneg_mode |->
    o_phy_mode.full_duplex == $past(i_mac_autoneg_select_full_duplex)) else $error("duplex wrong");
  led_one_dflt_a: assert property ($fell(i_srst) |=> o_first_led_pin == $past(any_link))
    else $error("first led default");
  led_two_dflt_a: assert property ($fell(i_srst) |=> o_second_led_pin == $past(any_link))
    else $error("second led default");
  resp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("response dropped");
  read_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data moved");
  read_upper_a: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("upper half set");
  mac_autoneg_select_c: cover property (o_phy_mode.autoneg_mode);
  slow_c: cover property (o_bvalid && !i_bready);
  led_c: cover property (o_first_led_pin && !o_second_led_pin);
endmodule
`default_nettype wire

/* File: bench/rpmls_phy_model.sv */
// Behavioural PHY: negotiation outcome and status levels.
// Assumes advertisement and link come from the bench on the system clock.
`timescale 1ns/1ps
`default_nettype none
module rpmls_phy_model (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic [3:0] i_adv,
  input wire logic i_link,
  // Status
  output var rpmls_pkg::rpmls_ind_type o_ind,
  output logic o_spd,
  output logic o_fdx
);
  logic [7:0] act_r = 8'h5a;
  // Best advertised mode wins: {100 full, 100 half, 10 full, 10 half}
  assign o_spd = |i_adv[3:2];
  assign o_fdx = i_adv[3] | (~|i_adv[3:2] & i_adv[1]);
  // Activity toggles freely so the LED paths never sit still
  always_ff @(posedge i_clk_sys) act_r <= {act_r[6:0], act_r[7] ^ act_r[5]};
  assign o_ind = {i_link & ~o_spd, o_fdx, |act_r[1:0], i_link & o_spd, act_r[0], act_r[1]};
endmodule
`default_nettype wire

/* File: bench/rpmls_tb.sv */
// Self-checking bench for the receive/PHY control block.
// Assumes the PHY model on the status side and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module rpmls_tb;
  localparam logic [31:0] A_RPC = 32'(rpmls_pkg::RPMLS_ADDR_RX_PHY_CONTROL);
  localparam logic [31:0] A_TXC = 32'(rpmls_pkg::RPMLS_ADDR_TX_CONTROL);
  localparam logic [31:0] A_PHC = 32'(rpmls_pkg::RPMLS_ADDR_PHY_CONTROL);
  localparam logic [31:0] A_STS = 32'(rpmls_pkg::RPMLS_ADDR_PHY_STATUS);
  localparam logic [1:0] OK = rpmls_pkg::RPMLS_RESP_OKAY;
  localparam logic [1:0] ERR = rpmls_pkg::RPMLS_RESP_SLVERR;
  logic clk = 0, srst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, link = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, seed = 32'h0001_3122;
  logic [3:0] adv = 0;
  wire logic awr, wrdy, bv, arr, rv, spd, fdx, fdx_ctl, abort, led_a, led_b;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire rpmls_pkg::rpmls_ind_type ind;
  wire rpmls_pkg::rpmls_mode_type mode;
  rpmls_pkg::rpmls_ind_type ind_q;
  int n_errors = 0, compares = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) ind_q <= ind;
  rpmls_phy_model rpmls_phy_model_inst (.i_clk_sys(clk), .i_adv(adv), .i_link(link),
    .o_ind(ind), .o_spd(spd), .o_fdx(fdx));
  rpmls_top rpmls_top_inst (.i_clk_sys(clk), .i_srst(srst), .i_ce(1'h1), .i_awvalid(awv),
    .o_awready(awr), .i_awaddr(awaddr), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wdata),
    .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arv),
    .o_arready(arr), .i_araddr(araddr), .o_rvalid(rv), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_ind(ind), .i_mac_autoneg_select_speed_100(spd), .i_mac_autoneg_select_full_duplex(fdx),
    .o_phy_mode(mode), .o_mac_full_duplex_ctl(fdx_ctl), .o_rx_abort_coll_en(abort),
    .o_first_led_pin(led_a), .o_second_led_pin(led_b));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic led_f(input logic [2:0] c, input rpmls_pkg::rpmls_ind_type i);
    logic [7:0] v;
    v = {i.tx_activity_ind, i.rx_activity_ind, i.link_100m_ind, i.txrx_activity_ind,
      i.full_duplex_ind, i.link_10m_ind, 1'h0, i.link_100m_ind | i.link_10m_ind};
    return v[c];
  endfunction
  // r is {speed, duplex, mac autoneg}, p is {phy speed, phy autoneg, phy duplex}
  function logic [2:0] mode_f(input logic [2:0] r, input logic [2:0] p);
    if (!r[0]) return {1'h0, r[2], r[1]};
    if (p[1]) return {1'h1, spd, fdx};
    return {1'h0, p[2], p[0]};
  endfunction
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n < 40) return;
    n_errors++;
    summarize();
  endtask
  // Ready is raised only after valid is seen, so the slave must hold its answer
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (bv && bready) break;
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
      bready <= bv;
    end
    bready <= 1'h0;
    bound(n);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    araddr <= a;
    arv <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rv && rready) break;
      if (arr) arv <= 1'h0;
      rready <= rv;
    end
    rready <= 1'h0;
    bound(n);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  initial begin
    logic [31:0] d;
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    link <= 1'h1;
    rd(A_RPC, 32'h0000_0000, OK);
    rd(A_STS, 32'h0000_0001, OK);
    repeat (4) begin
      d = rnd();
      wr(A_RPC, d & 32'h0000_38fc, OK);
      rd(A_RPC, d & 32'h0000_38fc, OK);
    end
    for (int j = 0; j < 64; j++) begin
      d = rnd();
      adv <= d[3:0];
      wr(A_RPC, {18'h0, j[2:0], 11'h0}, OK);
      wr(A_PHC, {18'h0, j[5:4], 3'h0, j[3], 8'h0}, OK);
      repeat (2) @(posedge clk);
      chk({29'h0, mode}, {29'h0, mode_f(j[2:0], j[5:3])});
    end
    for (int k = 0; k < 2; k++) begin
      wr(A_TXC, 32'(k), OK);
      repeat (2) @(posedge clk);
      chk({30'h0, fdx_ctl, abort}, {30'h0, k[0], ~k[0]});
    end
    for (int c = 0; c < 8; c++) begin
      link <= c[0];
      wr(A_RPC, {24'h0, c[2:0], ~c[2:0], 2'h0}, OK);
      repeat (2) @(posedge clk);
      repeat (6) begin
        @(negedge clk);
        chk({31'h0, led_a}, {31'h0, led_f(c[2:0], ind_q)});
        chk({31'h0, led_b}, {31'h0, led_f(~c[2:0], ind_q)});
      end
    end
    wr(32'h0000_0040, 32'h0000_ffff, ERR);
    rd(32'h0000_0040, 32'h0000_0000, ERR);
    summarize();
  end
endmodule
bind rpmls_top rpmls_properties rpmls_properties_inst (.*);
`default_nettype wire
